// ===== common/oct_regs.svh
// timing and encoding constants for the opcode cycle timing decoder
// Operation
// - unassigned opcode map positions are undefined operations with no behaviour
// - column timing: bit test branch 3/5, bit set clear 2/5, relative 2/3
// - control ops override: return int 8, return sub 5, swi 10, wait/stop 4
// - map adjustments in parentheses are added to the column base cycles
// - decimal adjust turns binary sum of packed digits into packed decimal
// - wait enters low-power wait mode, execution suspended until exit
// - stop enters deeper stop mode, execution halted until exit
`ifndef OCT_REGS_SVH
`define OCT_REGS_SVH
// =====================================================================
// special opcodes
`define OCT_OP_INT_RETURN 8'h80
`define OCT_OP_SUB_RETURN 8'h81
`define OCT_OP_SW_INT 8'h83
`define OCT_OP_DEC_ADJUST 8'h8D
`define OCT_OP_STOP 8'h8E
`define OCT_OP_WAIT 8'h8F
`define OCT_OP_ACC_TO_INDEX 8'h97
`define OCT_OP_INDEX_TO_ACC 8'h9F
`define OCT_OP_CLR_CARRY 8'h98
`define OCT_OP_SET_CARRY 8'h99
`define OCT_OP_UNMASK_INT 8'h9A
`define OCT_OP_MASK_INT 8'h9B
`define OCT_OP_SP_REINIT 8'h9C
`define OCT_OP_NOP 8'h9D
`define OCT_OP_BRANCH_SUB 8'hAD
`define OCT_OP_STORE_IX0 8'hF7
`define OCT_OP_STORE_IX0_B 8'hFF
`define OCT_OP_TEST_DIR 8'h3D
`define OCT_OP_TEST_IX1 8'h6D
`define OCT_OP_TEST_IX0 8'h7D
`define OCT_OP_JSR_DIR 8'hBD
`define OCT_OP_JSR_EXT 8'hCD
`define OCT_OP_JSR_IX2 8'hDD
`define OCT_OP_JSR_IX1 8'hED
`define OCT_OP_JSR_IX0 8'hFD
`define OCT_OP_JMP_IX2 8'hDC
// =====================================================================
// cycle counts of special instructions
`define OCT_CYC_INT_RETURN 4'h8
`define OCT_CYC_SUB_RETURN 4'h5
`define OCT_CYC_SW_INT 4'hA
`define OCT_CYC_LOW_POWER 4'h4
`define OCT_CYC_BRANCH_SUB 4'h5
`define OCT_CYC_SHORT_CTRL 4'h2
`define OCT_CYC_ONE 4'h1
`define OCT_CYC_DEFAULT 4'h2
// =====================================================================
// decimal adjust constants
`define OCT_BCD_LOW_FIX 8'h06
`define OCT_BCD_HIGH_FIX 8'h60
`define OCT_BCD_NIBBLE_MAX 4'h9
`define OCT_BCD_BYTE_MAX 8'h99
`endif

// ===== common/oct_pkg.sv
// types shared by the opcode cycle timing decoder
package oct_pkg;
  // decode answer for one opcode
  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] cycles;
    logic illegal;
    logic is_dec_adjust;
    logic is_wait;
    logic is_stop;
  } oct_decode_type;
  // decimal adjust operands and result
  typedef struct packed {
    logic [7:0] acc;
    logic carry;
    logic half_carry;
  } oct_bcd_in_type;
  typedef struct packed {
    logic [7:0] acc;
    logic carry;
    logic negative;
    logic zero;
  } oct_bcd_out_type;
  // power state of the core
  typedef enum logic [2:0] {
    OCT_RUN = 3'b001,
    OCT_WAIT = 3'b010,
    OCT_STOP = 3'b100
  } oct_power_type;
endpackage

// ===== verilog/oct_dec_adjust.sv
// decimal adjust of the accumulator after a packed decimal add
`timescale 1ns/100ps
`include "oct_regs.svh"
module oct_dec_adjust
  import oct_pkg::*;
(
  // operands
  input wire oct_bcd_in_type i_in,
  // adjusted result
  output oct_bcd_out_type o_out
);
  logic [7:0] fix;
  logic [7:0] sum;
  // =====================================================================
  // correction: low digit over 9 or half carry, high when the byte is over 99 or carry
  always_comb
  begin
    fix = 8'h00;
    if (i_in.half_carry || (i_in.acc[3:0] > `OCT_BCD_NIBBLE_MAX))
      fix = fix | `OCT_BCD_LOW_FIX;
    if (i_in.carry || (i_in.acc > `OCT_BCD_BYTE_MAX))
      fix = fix | `OCT_BCD_HIGH_FIX;
    sum = i_in.acc + fix;
    o_out.acc = sum;
    // carry is kept when already set, as the core never clears it here
    o_out.carry = i_in.carry || fix[6];
    o_out.negative = sum[7];
    o_out.zero = (sum == 8'h00);
  end
endmodule

// ===== verilog/oct_decoder.sv
// opcode length and cycle decoder with decimal adjust and low-power entry
`timescale 1ns/100ps
`include "oct_regs.svh"
module oct_decoder
  import oct_pkg::*;
(
  // clock and control
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  // fetched instruction
  input wire logic i_op_valid,
  input wire logic [7:0] i_opcode,
  // accumulator and flags for decimal adjust
  input wire logic [7:0] i_acc,
  input wire logic i_carry,
  input wire logic i_half_carry,
  // wake from wait or stop
  input wire logic i_wake,
  // decode answer
  output logic o_dec_valid,
  output logic [1:0] o_bytes,
  output logic [3:0] o_cycles,
  output logic o_illegal,
  // decimal adjust result
  output logic o_acc_we,
  output logic [7:0] o_acc,
  output logic o_carry,
  output logic o_negative,
  output logic o_zero,
  // power state
  output logic o_wait_mode,
  output logic o_stop_mode,
  output logic o_exec_halt
);
  oct_decode_type dec_next;
  oct_bcd_in_type bcd_in;
  oct_bcd_out_type bcd_out;
  oct_power_type power_reg;
  oct_power_type power_next;
  logic take;

  // =====================================================================
  // column timing plus special overrides
  function automatic oct_decode_type decode_op(input logic [7:0] op);
    oct_decode_type d;
    d = '{bytes: 2'd1, cycles: `OCT_CYC_DEFAULT, illegal: 1'b0, is_dec_adjust: 1'b0,
          is_wait: 1'b0, is_stop: 1'b0};
    unique case (op[7:4])
      4'h0: d = '{2'd3, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0};
      4'h1: d = '{2'd2, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0};
      4'h2: d = '{2'd2, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0};
      4'h3: d = '{2'd2, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0};
      4'h4, 4'h5: d = '{2'd1, 4'h2, 1'b0, 1'b0, 1'b0, 1'b0};
      4'h6: d = '{2'd2, 4'h6, 1'b0, 1'b0, 1'b0, 1'b0};
      4'h7: d = '{2'd1, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0};
      4'h8, 4'h9: d = '{2'd1, 4'h2, 1'b1, 1'b0, 1'b0, 1'b0};
      4'hA: d = '{2'd2, 4'h2, 1'b0, 1'b0, 1'b0, 1'b0};
      4'hB: d = '{2'd2, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0};
      4'hC: d = '{2'd3, 4'h4, 1'b0, 1'b0, 1'b0, 1'b0};
      4'hD: d = '{2'd3, 4'h5, 1'b0, 1'b0, 1'b0, 1'b0};
      4'hE: d = '{2'd2, 4'h4, 1'b0, 1'b0, 1'b0, 1'b0};
      4'hF: d = '{2'd1, 4'h3, 1'b0, 1'b0, 1'b0, 1'b0};
    endcase
    // read-modify-write columns: the listed rows are unassigned
    if (op[7:4] >= 4'h3 && op[7:4] <= 4'h7)
    begin
      unique case (op[3:0])
        4'h1, 4'h2, 4'h5, 4'hB, 4'hE: d.illegal = 1'b1;
        default: d.illegal = 1'b0;
      endcase
    end
    // adjusted entries: base plus the bracketed figure
    unique case (op)
      `OCT_OP_TEST_DIR, `OCT_OP_TEST_IX1, `OCT_OP_TEST_IX0,
      `OCT_OP_JMP_IX2: d.cycles = d.cycles - 4'h1;
      `OCT_OP_JSR_IX2, `OCT_OP_JSR_IX1, `OCT_OP_STORE_IX0,
      `OCT_OP_STORE_IX0_B: d.cycles = d.cycles + 4'h1;
      `OCT_OP_JSR_DIR, `OCT_OP_JSR_EXT, `OCT_OP_JSR_IX0: d.cycles = d.cycles + 4'h2;
      default: d.cycles = d.cycles;
    endcase
    // immediate column: compare-index store and the missing row are holes
    if (op == 8'hA7 || op == 8'hAC || op == 8'hAF)
      d.illegal = 1'b1;
    // control columns: only named codes are defined
    unique case (op)
      `OCT_OP_INT_RETURN: d = '{2'd1, `OCT_CYC_INT_RETURN, 1'b0, 1'b0, 1'b0, 1'b0};
      `OCT_OP_SUB_RETURN: d = '{2'd1, `OCT_CYC_SUB_RETURN, 1'b0, 1'b0, 1'b0, 1'b0};
      `OCT_OP_SW_INT: d = '{2'd1, `OCT_CYC_SW_INT, 1'b0, 1'b0, 1'b0, 1'b0};
      `OCT_OP_DEC_ADJUST: d = '{2'd1, `OCT_CYC_SHORT_CTRL, 1'b0, 1'b1, 1'b0, 1'b0};
      `OCT_OP_STOP: d = '{2'd1, `OCT_CYC_LOW_POWER, 1'b0, 1'b0, 1'b0, 1'b1};
      `OCT_OP_WAIT: d = '{2'd1, `OCT_CYC_LOW_POWER, 1'b0, 1'b0, 1'b1, 1'b0};
      `OCT_OP_ACC_TO_INDEX, `OCT_OP_INDEX_TO_ACC, `OCT_OP_UNMASK_INT, `OCT_OP_MASK_INT,
      `OCT_OP_SP_REINIT: d = '{2'd1, `OCT_CYC_SHORT_CTRL, 1'b0, 1'b0, 1'b0, 1'b0};
      `OCT_OP_CLR_CARRY, `OCT_OP_SET_CARRY,
      `OCT_OP_NOP: d = '{2'd1, `OCT_CYC_ONE, 1'b0, 1'b0, 1'b0, 1'b0};
      `OCT_OP_BRANCH_SUB: d = '{2'd2, `OCT_CYC_BRANCH_SUB, 1'b0, 1'b0, 1'b0, 1'b0};
      default: d = d;
    endcase
    // undefined codes carry no timing so the sequencer cannot act on them
    if (d.illegal)
      d = '{2'd0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0};
    return d;
  endfunction

  // =====================================================================
  // combinational decode and adjust
  assign dec_next = decode_op(i_opcode);
  assign take = i_op_valid && (power_reg == OCT_RUN);
  assign bcd_in = '{acc: i_acc, carry: i_carry, half_carry: i_half_carry};

  oct_dec_adjust u_adjust (
    .i_in(bcd_in),
    .o_out(bcd_out)
  );

  // =====================================================================
  // registered decode answer; fetch is ignored while halted
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_dec_valid <= 1'b0;
      o_bytes <= 2'd0;
      o_cycles <= 4'h0;
      o_illegal <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_dec_valid <= take;
      if (take)
      begin
        o_bytes <= dec_next.bytes;
        o_cycles <= dec_next.cycles;
        o_illegal <= dec_next.illegal;
      end
    end
  end

  // =====================================================================
  // decimal adjust write-back, one pulse per executed adjust
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_acc_we <= 1'b0;
      o_acc <= 8'h00;
      o_carry <= 1'b0;
      o_negative <= 1'b0;
      o_zero <= 1'b0;
    end
    else if (i_clk_en)
    begin
      o_acc_we <= take && dec_next.is_dec_adjust;
      if (take && dec_next.is_dec_adjust)
      begin
        o_acc <= bcd_out.acc;
        o_carry <= bcd_out.carry;
        o_negative <= bcd_out.negative;
        o_zero <= bcd_out.zero;
      end
    end
  end

  // =====================================================================
  // power state: wake leaves either mode; entry waits for the fetch
  always_comb
  begin
    power_next = power_reg;
    unique case (power_reg)
      OCT_RUN:
      begin
        if (take && dec_next.is_wait)
          power_next = OCT_WAIT;
        else if (take && dec_next.is_stop)
          power_next = OCT_STOP;
      end
      OCT_WAIT: if (i_wake) power_next = OCT_RUN;
      OCT_STOP: if (i_wake) power_next = OCT_RUN;
      default: power_next = OCT_RUN;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      power_reg <= OCT_RUN;
      o_wait_mode <= 1'b0;
      o_stop_mode <= 1'b0;
      o_exec_halt <= 1'b0;
    end
    else if (i_clk_en)
    begin
      power_reg <= power_next;
      o_wait_mode <= (power_next == OCT_WAIT);
      o_stop_mode <= (power_next == OCT_STOP);
      o_exec_halt <= (power_next != OCT_RUN);
    end
  end
endmodule

// ===== verification/oct_decoder_checker.sv
// assertion checker bound to the opcode cycle timing decoder
`timescale 1ns/100ps
module oct_decoder_checker
  import oct_pkg::*;
(
  // clock, control and instruction
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_clk_en,
  input wire logic i_op_valid,
  input wire logic [7:0] i_opcode,
  input wire logic i_wake,
  // decode and power outputs
  input wire logic o_dec_valid,
  input wire logic [1:0] o_bytes,
  input wire logic [3:0] o_cycles,
  input wire logic o_illegal,
  input wire logic o_acc_we,
  input wire logic o_wait_mode,
  input wire logic o_stop_mode,
  input wire logic o_exec_halt
);
  // =====================================================================
  // accepted opcode; halt outputs rise on the entry edge itself, and lp_reg masks the following edge as well
  logic take;
  logic lp_reg;
  assign take = i_clk_en && i_op_valid && !o_exec_halt && !lp_reg;
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      lp_reg <= 1'b0;
    else if (i_clk_en)
      lp_reg <= take && i_opcode[7:1] == 7'h47;
  end
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // =====================================================================
  // timing, decode and power state relations
  a_take_answer: assert property (take |=> o_dec_valid)
    else $error("accepted opcode got no answer");
  a_bit_column: assert property (take && i_opcode[7:4] == 4'h0 |=> o_bytes == 2'h3 && o_cycles == 4'h5)
    else $error("bit test column timing wrong");
  a_undef_flag: assert property (take && i_opcode inside {8'h31, 8'h82, 8'h9E, 8'hA7, 8'hAC, 8'hAF}
    |=> o_illegal && o_bytes == 2'h0 && o_cycles == 4'h0) else $error("undefined code not flagged");
  a_map_adjust: assert property (take && i_opcode inside {8'h3D, 8'hF7, 8'hFF} |=> o_cycles == 4'h4)
    else $error("adjusted cycle count wrong");
  a_adjust_write: assert property (take && i_opcode == 8'h8D |=> o_acc_we && o_bytes == 2'h1 && o_cycles == 4'h2)
    else $error("decimal adjust not written");
  a_wait_entry: assert property (take && i_opcode == 8'h8F
    |=> o_wait_mode && !o_stop_mode && o_exec_halt && o_cycles == 4'h4) else $error("wait mode not entered");
  a_stop_entry: assert property (take && i_opcode == 8'h8E
    |=> o_stop_mode && !o_wait_mode && o_exec_halt && o_cycles == 4'h4) else $error("stop mode not entered");
  a_halt_refuse: assert property (o_exec_halt |=> !o_dec_valid)
    else $error("opcode answered while halted");
  a_wake_exit: assert property (o_exec_halt && i_wake && i_clk_en |=> !o_exec_halt && !o_wait_mode && !o_stop_mode)
    else $error("wake did not leave low power");
  // main scenarios reached
  c_wait: cover property (take && i_opcode == 8'h8F);
  c_undef: cover property (o_dec_valid && o_illegal);
  c_wake: cover property (o_exec_halt && i_wake);
endmodule
bind oct_decoder oct_decoder_checker oct_decoder_checker_inst (.*);

// ===== verification/oct_decoder_tb.sv
// self-checking bench for the opcode cycle timing decoder
`timescale 1ns/100ps
module oct_decoder_tb;
  // =====================================================================
  // stimulus, observed outputs and bookkeeping
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_clk_en = 1'b1, i_op_valid = 1'b0;
  logic i_carry = 1'b0, i_half_carry = 1'b0, i_wake = 1'b0;
  logic [7:0] i_opcode = 8'h00, i_acc = 8'h00, o_acc;
  logic [1:0] o_bytes;
  logic [3:0] o_cycles;
  logic o_dec_valid, o_illegal, o_acc_we, o_carry, o_negative, o_zero, o_wait_mode, o_stop_mode, o_exec_halt;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  wire [7:0] dec = {o_dec_valid, o_illegal, o_bytes, o_cycles};
  wire [11:0] res = {o_acc_we, o_acc, o_carry, o_negative, o_zero};
  wire [3:0] mode = {o_wait_mode, o_stop_mode, o_exec_halt, o_dec_valid};
  // 10 MHz clock; enable is dropped only by the freeze test
  always #50 i_ref_clk = ~i_ref_clk;
  oct_decoder oct_decoder_inst (.*);
  // =====================================================================
  // comparison and drive helpers
  task automatic report(input logic [11:0] got, input logic [11:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_dec(input logic [7:0] got, input logic [7:0] exp);
    report({4'h0, got}, {4'h0, exp});
  endtask
  task automatic chk_res(input logic [11:0] got, input logic [11:0] exp);
    report(got, exp);
  endtask
  task automatic chk_mode(input logic [3:0] got, input logic [3:0] exp);
    report({8'h00, got}, {8'h00, exp});
  endtask
  task automatic tick();
    @(posedge i_ref_clk);
    #1;
  endtask
  // one opcode held for a single edge; its answer is visible on return
  task automatic issue(input logic [7:0] op);
    tick();
    i_opcode = op;
    i_op_valid = 1'b1;
    tick();
    i_op_valid = 1'b0;
  endtask
  // =====================================================================
  // every column plus adjusted, control and undefined codes, back to back
  task automatic t_columns();
    logic [15:0] tbl [39] = '{16'h0035, 16'h1F25, 16'h2F23, 16'h3D24, 16'h4012, 16'h5012, 16'h6D25, 16'h7D14,
      16'h8018, 16'h8115, 16'h831A, 16'h9712, 16'h9F12, 16'h9A12, 16'h9B12, 16'h9C12, 16'h9811, 16'h9911, 16'h9D11,
      16'hAD25, 16'hA222, 16'hB723, 16'hC634, 16'hDC34, 16'hDD36, 16'hED25, 16'hFD15, 16'hBD25, 16'hCD36, 16'hE624,
      16'hF714, 16'hFF14, 16'hF013, 16'h3100, 16'h8200, 16'h9E00, 16'hA700, 16'hAC00, 16'hAF00};
    for (int k = 0; k <= 39; k++)
    begin
      tick();
      if (k > 0)
        chk_dec(dec, {1'b1, tbl[k-1][7:4] == 4'h0, tbl[k-1][5:0]});
      i_op_valid = k < 39;
      i_opcode = tbl[k % 39][15:8];
    end
    $display("column timing test done");
  endtask
  // decimal adjust: no fix, low fix, high fix, both, carry kept
  task automatic t_adjust();
    logic [7:0] ai [7] = '{8'h15, 8'h1A, 8'h13, 8'hA0, 8'h9A, 8'h50, 8'h99};
    logic [7:0] ae [7] = '{8'h15, 8'h20, 8'h19, 8'h00, 8'h00, 8'hB0, 8'h99};
    logic [1:0] ch [7] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h2, 2'h0};
    logic ec [7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int k = 0; k < 7; k++)
    begin
      i_acc = ai[k];
      {i_carry, i_half_carry} = ch[k];
      issue(8'h8D);
      chk_res(res, {1'b1, ae[k], ec[k], ae[k][7], ae[k] == 8'h00});
      chk_dec(dec, 8'h92);
    end
    $display("decimal adjust test done");
  endtask
  // wait then stop: opcode offered while halted is refused through the wake edge and answered on the next
  task automatic t_power();
    for (int k = 0; k < 2; k++)
    begin
      tick();
      i_opcode = k ? 8'h8E : 8'h8F;
      i_op_valid = 1'b1;
      tick();
      chk_dec(dec, 8'h94);
      i_opcode = 8'h9D;
      repeat (2) tick();
      chk_mode(mode, {!k[0], k[0], 2'b10});
      i_wake = 1'b1;
      tick();
      i_wake = 1'b0;
      chk_mode(mode, 4'h0);
      tick();
      i_op_valid = 1'b0;
      chk_dec(dec, 8'h91);
    end
    $display("low power test done");
  endtask
  // enable low: a wait opcode offered then must neither answer nor enter low power
  task automatic t_freeze();
    tick();
    i_clk_en = 1'b0;
    issue(8'h8F);
    chk_dec(dec, 8'h11);
    chk_mode(mode, 4'h0);
    i_clk_en = 1'b1;
    tick();
    chk_dec(dec, 8'h11);
    $display("clock enable test done");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // =====================================================================
  // main sequence and hang guard
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    t_columns();
    t_adjust();
    t_power();
    t_freeze();
    wrap_up();
  end
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      wrap_up();
    end
  end
endmodule
